/* bench/flash_link_checker.sv */
`timescale 1ns/1ps
module flash_link_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic serial_clk,
	input wire logic serial_in_line,
	input wire logic serial_out_line
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence sclk_high_phase;
		serial_clk [*4] ##1 !serial_clk;
	endsequence

	sequence sclk_low_phase;
		(!serial_clk) [*4];
	endsequence

	sequence held_deselect;
		chip_select_n [*4];
	endsequence

	chk_sclk_high_len: assert property ($rose(serial_clk) |-> sclk_high_phase)
		else $error("serial clock high phase has the wrong length");
	chk_sclk_low_len: assert property ($fell(serial_clk) && !chip_select_n |-> sclk_low_phase)
		else $error("serial clock low phase is too short");
	chk_sclk_idle_low: assert property (chip_select_n |-> !serial_clk)
		else $error("serial clock runs while deselected");
	chk_cs_gap_min: assert property ($rose(chip_select_n) |-> chip_select_n [*3])
		else $error("deselect gap between frames is too short");
	chk_out_quiet: assert property (held_deselect |-> !serial_out_line)
		else $error("output line not released after deselect");
	// Output bits move only after a falling edge, so a whole high phase sees one value.
	chk_out_steady: assert property ($rose(serial_clk) |-> ##1 ($stable(serial_out_line)) [*3])
		else $error("output line changed while serial clock high");
	chk_in_steady: assert property ($rose(serial_clk) |-> ##1 ($stable(serial_in_line)) [*3])
		else $error("input line changed while serial clock high");
	// The host raises select on the edge that ends the last high phase, so the
	// previous sample still shows the clock high and the current one shows it low.
	chk_deselect_low: assert property ($rose(chip_select_n) |-> !serial_clk && $past(serial_clk, 1))
		else $error("deselect not aligned with the last falling clock edge");

	cov_frame_end: cover property ($rose(chip_select_n));
endmodule : flash_link_checker

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic                     mclk;
	logic                     rst;
	logic                     array_busy;
	logic                     erase_suspended;
	logic                     erase_failed;
	logic                     program_failed;
	logic                     program_suspended;
	logic                     protect_error;
	logic                     write_enabled;
	logic                     write_in_progress;
	logic                     four_byte_active;
	logic [3:0]               dummy_cycles_x1;
	logic [3:0]               dummy_cycles_x4;
	logic [15:0]              cfg_value;
	logic                     op_start;
	flash_regs_pkg::host_op_t op_sel;
	logic [3:0]               cfg_dummy;
	logic                     cfg_three_byte;
	logic                     op_busy;
	logic                     op_done;
	logic [15:0]              op_rdata;
	int                       n_mismatch;
	int                       check_count;
	int                       cyc;
	int                       busy_cnt;
	logic [4:0]               fv;
	logic [3:0]               dv;
	logic [15:0]              ev;
	logic [3:0]               dtab [4];

	localparam int WR_CYCLES = 20;

	flash_link_if link_if ();

	flash_cfg_device #(.CFG_WRITE_CYCLES(WR_CYCLES)) u_flash_cfg_device (
		.mclk              (mclk),
		.rst               (rst),
		.link              (link_if),
		.array_busy        (array_busy),
		.erase_suspended   (erase_suspended),
		.erase_failed      (erase_failed),
		.program_failed    (program_failed),
		.program_suspended (program_suspended),
		.protect_error     (protect_error),
		.write_enabled     (write_enabled),
		.write_in_progress (write_in_progress),
		.four_byte_active  (four_byte_active),
		.dummy_cycles_x1   (dummy_cycles_x1),
		.dummy_cycles_x4   (dummy_cycles_x4),
		.cfg_value         (cfg_value)
	);

	flash_cfg_host u_flash_cfg_host (
		.mclk           (mclk),
		.rst            (rst),
		.link           (link_if),
		.op_start       (op_start),
		.op_sel         (op_sel),
		.cfg_dummy      (cfg_dummy),
		.cfg_three_byte (cfg_three_byte),
		.op_busy        (op_busy),
		.op_done        (op_done),
		.op_rdata       (op_rdata)
	);

	flash_link_checker u_flash_link_checker (
		.mclk            (mclk),
		.rst             (rst),
		.chip_select_n   (link_if.chip_select_n),
		.serial_clk      (link_if.serial_clk),
		.serial_in_line  (link_if.serial_in_line),
		.serial_out_line (link_if.serial_out_line)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	// One host operation: a single-cycle start, then a bounded wait for the done pulse.
	task automatic run(input flash_regs_pkg::host_op_t op, input logic [3:0] d, input logic three);
		int n;
		@(negedge mclk);
		op_sel = op;
		cfg_dummy = d;
		cfg_three_byte = three;
		op_start = 1'b1;
		@(negedge mclk);
		op_start = 1'b0;
		check({15'h0000, op_busy}, 16'h0001);
		n = 0;
		while (op_done !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		check({15'h0000, op_done}, 16'h0001);
		check({15'h0000, op_busy}, 16'h0000);
	endtask : run

	function automatic logic [15:0] flags_exp(input logic rdy, input logic [4:0] v, input logic a4);
		return {8'h00, rdy, v[4:2], 1'b0, v[1:0], a4};
	endfunction : flags_exp

	always @(posedge mclk) begin
		cyc++;
		if (write_in_progress === 1'b1)
			busy_cnt++;
		if (cyc == 60000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		rst = 1'b1;
		{array_busy, erase_suspended, erase_failed, program_failed, program_suspended, protect_error} = 6'h00;
		op_start = 1'b0;
		op_sel = flash_regs_pkg::HOP_READ_FLAGS;
		cfg_dummy = 4'h0;
		cfg_three_byte = 1'b1;
		n_mismatch = 0;
		check_count = 0;
		cyc = 0;
		busy_cnt = 0;
		dtab = '{4'h0, 4'h1, 4'hE, 4'hF};
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		check(cfg_value, 16'hFFFF);
		check({4'h0, dummy_cycles_x1, 4'h0, dummy_cycles_x4}, 16'h080A);
		run(flash_regs_pkg::HOP_READ_CFG, 4'h0, 1'b1);
		check(op_rdata, 16'hFFFF);
		// Each event flag alone, then all of them together.
		for (int i = 0; i < 6; i++) begin
			fv = (i < 5) ? (5'h01 << i) : 5'h1F;
			{erase_suspended, erase_failed, program_failed, program_suspended, protect_error} = fv;
			run(flash_regs_pkg::HOP_READ_FLAGS, 4'h0, 1'b1);
			check({8'h00, op_rdata[7:0]}, flags_exp(1'b1, fv, 1'b0));
		end
		{erase_suspended, erase_failed, program_failed, program_suspended, protect_error} = 5'h00;
		array_busy = 1'b1;
		run(flash_regs_pkg::HOP_READ_FLAGS, 4'h0, 1'b1);
		check({8'h00, op_rdata[7:0]}, 16'h0000);
		check({15'h0000, write_in_progress}, 16'h0001);
		run(flash_regs_pkg::HOP_WRITE_ENABLE, 4'h0, 1'b1);
		check({15'h0000, write_enabled}, 16'h0000);
		array_busy = 1'b0;
		run(flash_regs_pkg::HOP_WRITE_ENABLE, 4'h0, 1'b1);
		check({15'h0000, write_enabled}, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			dv = dtab[i];
			ev = {dv, 7'h7F, 1'b1, 3'h7, i[0]};
			busy_cnt = 0;
			run(flash_regs_pkg::HOP_WRITE_CFG, dv, i[0]);
			check({15'h0000, op_rdata[7]}, 16'h0001);
			check({15'h0000, busy_cnt >= WR_CYCLES}, 16'h0001);
			check(cfg_value, ev);
			check({12'h000, dummy_cycles_x1}, (dv == 4'h0 || dv == 4'hF) ? 16'h0008 : {12'h000, dv});
			check({12'h000, dummy_cycles_x4}, (dv == 4'h0 || dv == 4'hF) ? 16'h000A : {12'h000, dv});
			check({15'h0000, four_byte_active}, {15'h0000, ~i[0]});
			check({15'h0000, write_enabled}, 16'h0000);
			run(flash_regs_pkg::HOP_READ_CFG, 4'h0, 1'b1);
			check(op_rdata, ev);
			run(flash_regs_pkg::HOP_READ_FLAGS, 4'h0, 1'b1);
			check({8'h00, op_rdata[7:0]}, flags_exp(1'b1, 5'h00, ~i[0]));
		end
		final_report();
	end
endmodule : tb

/* core/flash_cfg_device.sv */
`timescale 1ns/1ps
module flash_cfg_device #(
	parameter int unsigned CFG_WRITE_CYCLES = flash_regs_pkg::CFG_WRITE_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	flash_link_if.device     link,
	input  wire logic        array_busy,
	input  wire logic        erase_suspended,
	input  wire logic        erase_failed,
	input  wire logic        program_failed,
	input  wire logic        program_suspended,
	input  wire logic        protect_error,
	output logic             write_enabled,
	output logic             write_in_progress,
	output logic             four_byte_active,
	output logic [3:0]       dummy_cycles_x1,
	output logic [3:0]       dummy_cycles_x4,
	output logic [15:0]      cfg_value
);
	localparam int TW = $clog2(CFG_WRITE_CYCLES + 1);

	logic                      cs_n_s;
	logic                      sclk_s;
	logic                      si_s;
	logic                      cs_prev_q;
	logic                      sclk_prev_q;
	logic                      rise;
	logic                      fall;
	logic                      wip;
	logic [7:0]                flags;
	logic [7:0]                status;
	flash_regs_pkg::dev_state_t state_q, state_d;
	logic [4:0]                cnt_q, cnt_d;
	logic [15:0]               sh_q, sh_d;
	logic [15:0]               out_q, out_d;
	logic                      so_q, so_d;
	logic                      wel_q, wel_d;
	logic                      busy_q, busy_d;
	logic [TW-1:0]             timer_q, timer_d;
	logic [15:0]               cfg_q, cfg_d;
	logic [15:0]               pend_q, pend_d;
	logic [3:0]                dx1_q, dx1_d;
	logic [3:0]                dx4_q, dx4_d;

	// The pins are asynchronous to mclk, so all three pass one synchroniser together
	// and keep their relative timing.
	sync2 #(
		.WIDTH       (3),
		.RESET_VALUE (3'h4)
	) u_pin_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({link.chip_select_n, link.serial_clk, link.serial_in_line}),
		.q    ({cs_n_s, sclk_s, si_s})
	);

	assign rise = !cs_n_s && sclk_s && !sclk_prev_q;
	assign fall = !cs_n_s && !sclk_s && sclk_prev_q;
	assign wip  = busy_q || array_busy;

	always_comb begin
		flags                               = 8'h00;
		flags[flash_regs_pkg::FSR_READY]      = !wip;
		flags[flash_regs_pkg::FSR_ERASE_SUSP] = erase_suspended;
		flags[flash_regs_pkg::FSR_ERASE_FAIL] = erase_failed;
		flags[flash_regs_pkg::FSR_PROG_FAIL]  = program_failed;
		flags[flash_regs_pkg::FSR_PROG_SUSP]  = program_suspended;
		flags[flash_regs_pkg::FSR_PROTECT]    = protect_error;
		// A cleared address bit in the configuration selects four-byte addressing.
		flags[flash_regs_pkg::FSR_ADDR4]      = !cfg_q[flash_regs_pkg::CFG_ADDR_BIT];
		status                              = 8'h00;
		status[flash_regs_pkg::STATUS_WIP]    = wip;
		status[flash_regs_pkg::STATUS_WEL]    = wel_q;
	end

	always_comb begin
		logic [15:0] word;
		logic        load;
		logic [3:0]  field;
		word    = 16'h0000;
		load    = 1'b0;
		field   = 4'h0;
		state_d = state_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		out_d   = out_q;
		so_d    = so_q;
		wel_d   = wel_q;
		busy_d  = busy_q;
		timer_d = timer_q;
		cfg_d   = cfg_q;
		pend_d  = pend_q;

		if (busy_q) begin
			timer_d = timer_q - TW'(1);
			if (timer_q == TW'(1)) begin
				busy_d = 1'b0;
				cfg_d  = pend_q;
				wel_d  = 1'b0;
			end
		end

		if (cs_n_s) begin
			so_d    = 1'b0;
			state_d = flash_regs_pkg::D_IDLE;
			if (!cs_prev_q) begin
				case (state_q)
					flash_regs_pkg::D_WREN: begin
						if (!wip) begin
							wel_d = 1'b1;
						end
					end
					flash_regs_pkg::D_WRDI: begin
						if (!wip) begin
							wel_d = 1'b0;
						end
					end
					flash_regs_pkg::D_TAKE_CFG: begin
						// Only an exact 16-bit frame with the latch set starts the timed update.
						if (cnt_q == flash_regs_pkg::CFG_DATA_BITS && wel_q && !wip) begin
							pend_d  = sh_q;
							busy_d  = 1'b1;
							timer_d = TW'(CFG_WRITE_CYCLES);
						end
					end
					default: begin
					end
				endcase
			end
		end else if (state_q == flash_regs_pkg::D_IDLE) begin
			state_d = flash_regs_pkg::D_OPCODE;
			cnt_d   = 5'h00;
		end else if (rise) begin
			case (state_q)
				flash_regs_pkg::D_OPCODE: begin
					sh_d  = {sh_q[14:0], si_s};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == 5'h07) begin
						cnt_d = 5'h00;
						case ({sh_q[6:0], si_s})
							flash_regs_pkg::OP_READ_FLAGS:    state_d = flash_regs_pkg::D_SEND_FLAGS;
							flash_regs_pkg::OP_READ_STATUS:   state_d = flash_regs_pkg::D_SEND_STATUS;
							flash_regs_pkg::OP_READ_CFG:      state_d = flash_regs_pkg::D_SEND_CFG;
							flash_regs_pkg::OP_WRITE_CFG:     state_d = flash_regs_pkg::D_TAKE_CFG;
							flash_regs_pkg::OP_WRITE_ENABLE:  state_d = flash_regs_pkg::D_WREN;
							flash_regs_pkg::OP_WRITE_DISABLE: state_d = flash_regs_pkg::D_WRDI;
							default:                          state_d = flash_regs_pkg::D_IGNORE;
						endcase
					end
				end
				flash_regs_pkg::D_TAKE_CFG: begin
					sh_d = {sh_q[14:0], si_s};
					// Saturating so that any frame longer than 16 bits is refused.
					if (cnt_q != 5'h1F) begin
						cnt_d = cnt_q + 5'h01;
					end
				end
				flash_regs_pkg::D_WREN, flash_regs_pkg::D_WRDI: begin
					state_d = flash_regs_pkg::D_IGNORE;
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			case (state_q)
				flash_regs_pkg::D_SEND_FLAGS: begin
					// A fresh snapshot every byte, so a long poll sees the operation finish.
					load  = (cnt_q[2:0] == 3'h0);
					word  = {flags, 8'h00};
					cnt_d = cnt_q + 5'h01;
				end
				flash_regs_pkg::D_SEND_STATUS: begin
					load  = (cnt_q[2:0] == 3'h0);
					word  = {status, 8'h00};
					cnt_d = cnt_q + 5'h01;
				end
				flash_regs_pkg::D_SEND_CFG: begin
					// Loaded once; shifting in zeros gives the trailing zero bits.
					load = (cnt_q == 5'h00);
					word = cfg_q;
					if (cnt_q != flash_regs_pkg::CFG_DATA_BITS) begin
						cnt_d = cnt_q + 5'h01;
					end
				end
				default: begin
				end
			endcase
			if (state_q == flash_regs_pkg::D_SEND_FLAGS || state_q == flash_regs_pkg::D_SEND_STATUS ||
				state_q == flash_regs_pkg::D_SEND_CFG) begin
				if (load) begin
					so_d  = word[15];
					out_d = {word[14:0], 1'b0};
				end else begin
					so_d  = out_q[15];
					out_d = {out_q[14:0], 1'b0};
				end
			end
		end

		field = cfg_d[flash_regs_pkg::CFG_DUMMY_MSB:flash_regs_pkg::CFG_DUMMY_LSB];
		if (field == flash_regs_pkg::DUMMY_LOW_RAW || field == flash_regs_pkg::DUMMY_HIGH_RAW) begin
			dx1_d = flash_regs_pkg::DUMMY_DEFAULT_X1;
			dx4_d = flash_regs_pkg::DUMMY_DEFAULT_X4;
		end else begin
			dx1_d = field;
			dx4_d = field;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q     <= flash_regs_pkg::D_IDLE;
			cs_prev_q   <= 1'b1;
			sclk_prev_q <= 1'b0;
			cnt_q       <= 5'h00;
			sh_q        <= 16'h0000;
			out_q       <= 16'h0000;
			so_q        <= 1'b0;
			wel_q       <= 1'b0;
			busy_q      <= 1'b0;
			timer_q     <= '0;
			cfg_q       <= flash_regs_pkg::CFG_RESET;
			pend_q      <= flash_regs_pkg::CFG_RESET;
			dx1_q       <= flash_regs_pkg::DUMMY_DEFAULT_X1;
			dx4_q       <= flash_regs_pkg::DUMMY_DEFAULT_X4;
		end else begin
			state_q     <= state_d;
			cs_prev_q   <= cs_n_s;
			sclk_prev_q <= sclk_s;
			cnt_q       <= cnt_d;
			sh_q        <= sh_d;
			out_q       <= out_d;
			so_q        <= so_d;
			wel_q       <= wel_d;
			busy_q      <= busy_d;
			timer_q     <= timer_d;
			cfg_q       <= cfg_d;
			pend_q      <= pend_d;
			dx1_q       <= dx1_d;
			dx4_q       <= dx4_d;
		end
	end

	assign link.serial_out_line = so_q;
	assign write_enabled        = wel_q;
	assign write_in_progress    = wip;
	assign four_byte_active     = flags[flash_regs_pkg::FSR_ADDR4];
	assign dummy_cycles_x1      = dx1_q;
	assign dummy_cycles_x4      = dx4_q;
	assign cfg_value            = cfg_q;
endmodule : flash_cfg_device

/* core/flash_cfg_host.sv */
`timescale 1ns/1ps
module flash_cfg_host #(
	parameter int SCLK_HALF = flash_regs_pkg::SCLK_HALF_CYCLES,
	parameter int CS_GAP    = flash_regs_pkg::CS_GAP_CYCLES
) (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	flash_link_if.host                    link,
	input  wire logic                     op_start,
	input  wire flash_regs_pkg::host_op_t op_sel,
	input  wire logic [3:0]               cfg_dummy,
	input  wire logic                     cfg_three_byte,
	output logic                          op_busy,
	output logic                          op_done,
	output logic [15:0]                   op_rdata
);
	logic                        so_s;
	flash_regs_pkg::host_state_t state_q, state_d;
	flash_regs_pkg::host_phase_t phase_q, phase_d;
	flash_regs_pkg::host_op_t    op_q, op_d;
	logic [7:0]                  div_q, div_d;
	logic [5:0]                  bit_q, bit_d;
	logic [5:0]                  tot_q, tot_d;
	logic [23:0]                 tx_q, tx_d;
	logic [15:0]                 rx_q, rx_d;
	logic [15:0]                 rdata_q, rdata_d;
	logic                        done_q, done_d;
	logic                        cs_n_q, cs_n_d;
	logic                        sclk_q, sclk_d;
	logic                        si_q, si_d;
	logic [15:0]                 cfg_word;

	sync2 #(
		.WIDTH       (1),
		.RESET_VALUE (1'h0)
	) u_so_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    (link.serial_out_line),
		.q    (so_s)
	);

	// Fill bits are forced high and the dummy nibble goes to the top field.
	assign cfg_word = {cfg_dummy, flash_regs_pkg::CFG_FILL_HIGH, flash_regs_pkg::CFG_FILL_BIT4,
		flash_regs_pkg::CFG_FILL_LOW, cfg_three_byte};

	always_comb begin
		logic        go;
		logic [7:0]  l_op;
		logic [5:0]  l_tot;
		go      = 1'b0;
		l_op    = flash_regs_pkg::OP_READ_FLAGS;
		l_tot   = 6'h10;
		state_d = state_q;
		phase_d = phase_q;
		op_d    = op_q;
		div_d   = div_q;
		bit_d   = bit_q;
		tot_d   = tot_q;
		tx_d    = tx_q;
		rx_d    = rx_q;
		rdata_d = rdata_q;
		done_d  = 1'b0;
		cs_n_d  = cs_n_q;
		sclk_d  = sclk_q;
		si_d    = si_q;
		case (state_q)
			flash_regs_pkg::H_IDLE: begin
				if (op_start) begin
					go      = 1'b1;
					op_d    = op_sel;
					phase_d = flash_regs_pkg::PH_SEND;
					case (op_sel)
						flash_regs_pkg::HOP_READ_CFG: begin
							l_op  = flash_regs_pkg::OP_READ_CFG;
							l_tot = 6'h18;
						end
						flash_regs_pkg::HOP_WRITE_ENABLE: begin
							l_op  = flash_regs_pkg::OP_WRITE_ENABLE;
							l_tot = 6'h08;
						end
						flash_regs_pkg::HOP_WRITE_CFG: begin
							l_op    = flash_regs_pkg::OP_WRITE_ENABLE;
							l_tot   = 6'h08;
							phase_d = flash_regs_pkg::PH_WREN;
						end
						default: begin
						end
					endcase
				end
			end
			flash_regs_pkg::H_FRAME: begin
				div_d  = (div_q == 8'(2 * SCLK_HALF - 1)) ? 8'h00 : div_q + 8'h01;
				sclk_d = (div_d >= 8'(SCLK_HALF));
				// Sampled at the end of the high phase to cover the device's pin delay.
				if (div_q == 8'(2 * SCLK_HALF - 1)) begin
					rx_d  = {rx_q[14:0], so_s};
					tx_d  = {tx_q[22:0], 1'b0};
					si_d  = tx_q[22];
					bit_d = bit_q + 6'h01;
					if (bit_q == tot_q - 6'h01) begin
						state_d = flash_regs_pkg::H_GAP;
						cs_n_d  = 1'b1;
						sclk_d  = 1'b0;
						si_d    = 1'b0;
						div_d   = 8'h00;
					end
				end
			end
			default: begin
				div_d = div_q + 8'h01;
				if (div_q >= 8'(CS_GAP - 1)) begin
					case (phase_q)
						flash_regs_pkg::PH_WREN: begin
							go      = 1'b1;
							l_op    = flash_regs_pkg::OP_WRITE_CFG;
							l_tot   = 6'h18;
							phase_d = flash_regs_pkg::PH_SEND;
						end
						default: begin
							if ((op_q == flash_regs_pkg::HOP_WRITE_CFG && phase_q == flash_regs_pkg::PH_SEND) ||
								(phase_q == flash_regs_pkg::PH_POLL && !rx_q[flash_regs_pkg::FSR_READY])) begin
								go      = 1'b1;
								l_op    = flash_regs_pkg::OP_READ_FLAGS;
								l_tot   = 6'h10;
								phase_d = flash_regs_pkg::PH_POLL;
							end else begin
								state_d = flash_regs_pkg::H_IDLE;
								done_d  = 1'b1;
								rdata_d = rx_q;
							end
						end
					endcase
				end
			end
		endcase
		if (go) begin
			state_d = flash_regs_pkg::H_FRAME;
			tx_d    = {l_op, cfg_word};
			tot_d   = l_tot;
			bit_d   = 6'h00;
			div_d   = 8'h00;
			rx_d    = 16'h0000;
			cs_n_d  = 1'b0;
			sclk_d  = 1'b0;
			si_d    = l_op[7];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= flash_regs_pkg::H_IDLE;
			phase_q <= flash_regs_pkg::PH_SEND;
			op_q    <= flash_regs_pkg::HOP_READ_FLAGS;
			div_q   <= 8'h00;
			bit_q   <= 6'h00;
			tot_q   <= 6'h00;
			tx_q    <= 24'h000000;
			rx_q    <= 16'h0000;
			rdata_q <= 16'h0000;
			done_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			sclk_q  <= 1'b0;
			si_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			op_q    <= op_d;
			div_q   <= div_d;
			bit_q   <= bit_d;
			tot_q   <= tot_d;
			tx_q    <= tx_d;
			rx_q    <= rx_d;
			rdata_q <= rdata_d;
			done_q  <= done_d;
			cs_n_q  <= cs_n_d;
			sclk_q  <= sclk_d;
			si_q    <= si_d;
		end
	end

	assign link.chip_select_n  = cs_n_q;
	assign link.serial_clk     = sclk_q;
	assign link.serial_in_line = si_q;
	assign op_busy             = (state_q != flash_regs_pkg::H_IDLE);
	assign op_done             = done_q;
	assign op_rdata            = rdata_q;
endmodule : flash_cfg_host

/* core/flash_link_if.sv */
`timescale 1ns/1ps
interface flash_link_if;
	logic chip_select_n;
	logic serial_clk;
	logic serial_in_line;
	logic serial_out_line;

	modport device (
		input  chip_select_n,
		input  serial_clk,
		input  serial_in_line,
		output serial_out_line
	);

	modport host (
		output chip_select_n,
		output serial_clk,
		output serial_in_line,
		input  serial_out_line
	);
endinterface : flash_link_if

/* core/flash_regs_pkg.sv */
package flash_regs_pkg;

	// Command codes, most significant bit first on the serial input line.
	localparam logic [7:0] OP_READ_STATUS   = 8'h05;
	localparam logic [7:0] OP_READ_FLAGS    = 8'h70;
	localparam logic [7:0] OP_READ_CFG      = 8'hB5;
	localparam logic [7:0] OP_WRITE_CFG     = 8'hB1;
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

	// Flag status register bit positions.
	localparam int FSR_READY      = 7;
	localparam int FSR_ERASE_SUSP = 6;
	localparam int FSR_ERASE_FAIL = 5;
	localparam int FSR_PROG_FAIL  = 4;
	localparam int FSR_PROG_SUSP  = 2;
	localparam int FSR_PROTECT    = 1;
	localparam int FSR_ADDR4      = 0;

	// Main status register bit positions.
	localparam int STATUS_WIP = 0;
	localparam int STATUS_WEL = 1;

	// Configuration register layout and reset value.
	localparam int              CFG_DUMMY_MSB    = 15;
	localparam int              CFG_DUMMY_LSB    = 12;
	localparam int              CFG_ADDR_BIT     = 0;
	localparam logic [15:0]     CFG_RESET        = 16'hFFFF;
	localparam logic [6:0]      CFG_FILL_HIGH    = 7'h7F;
	localparam logic            CFG_FILL_BIT4    = 1'h1;
	localparam logic [2:0]      CFG_FILL_LOW     = 3'h7;
	localparam logic [3:0]      DUMMY_LOW_RAW    = 4'h0;
	localparam logic [3:0]      DUMMY_HIGH_RAW   = 4'hF;
	localparam logic [3:0]      DUMMY_DEFAULT_X1 = 4'h8;
	localparam logic [3:0]      DUMMY_DEFAULT_X4 = 4'hA;
	localparam logic [4:0]      CFG_DATA_BITS    = 5'h10;

	// Timing.
	localparam int MCLK_FREQ_HZ      = 25_000_000;
	localparam int MCLK_PERIOD_NS    = 40;
	localparam int CFG_WRITE_TIME_US = 5000;
	localparam int CFG_WRITE_CYCLES  = CFG_WRITE_TIME_US * (MCLK_FREQ_HZ / 1_000_000);
	localparam int SCLK_PERIOD_NS    = 320;
	localparam int SCLK_HALF_CYCLES  = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	localparam int CS_GAP_NS         = 100;
	localparam int CS_GAP_CYCLES     = (CS_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

	typedef enum logic [3:0] {
		D_IDLE,
		D_OPCODE,
		D_SEND_STATUS,
		D_SEND_FLAGS,
		D_SEND_CFG,
		D_TAKE_CFG,
		D_WREN,
		D_WRDI,
		D_IGNORE
	} dev_state_t;

	typedef enum logic [1:0] {
		HOP_READ_FLAGS,
		HOP_READ_CFG,
		HOP_WRITE_ENABLE,
		HOP_WRITE_CFG
	} host_op_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_FRAME,
		H_GAP
	} host_state_t;

	typedef enum logic [1:0] {
		PH_WREN,
		PH_SEND,
		PH_POLL
	} host_phase_t;

endpackage : flash_regs_pkg

/* core/sync2.sv */
`timescale 1ns/1ps
module sync2 #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_q <= RESET_VALUE;
			q      <= RESET_VALUE;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sync2
